// >>> core/host_coprocessor_mailbox.sv
// Host/coprocessor mailbox with an inbound byte FIFO and both interrupts.
// Assumes both access ports are synchronous to clk and that a select
// stays high for a whole bus cycle and drops between cycles.
// Overview of operation
// - All local interrupt sources share equal priority.
// - Serial controllers may request local interrupts.
// - Enabled host mailbox access raises local interrupt.
// - Local acknowledge of mailbox interrupt drives FCh.
// - Disabled: host access raises no local interrupt.
// - Enabled vector write latches byte, asserts request.
// - Host acknowledge drives vector and drops request together.
// - Disabled vector write does nothing at all.
// - Early command write just replaces stored byte.
// - Command write sets available, clears empty.
// - Local read keeps handshake; writing 1 empties.
// - Status write stores only bits D5 to D2.
// - Host status read sets status empty flag.
// - No hardware new-status bit; software reserves one.
// - Host write sets available; local read of the last byte empties.
// - Outbound write sets available; host read empties.
// - Reset sets outbound data empty.
// - Reset clears inbound data available.
// - Host pending flag follows asserted request line.
`default_nettype none

// ---------------------------------------------------------------------
// Byte FIFO
// ---------------------------------------------------------------------
module mailbox_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 8
) (
    input  wire logic             clk,
    input  wire logic             rst,
    input  wire logic             inValid,
    output logic                  inReady,
    input  wire logic [WIDTH-1:0] inData,
    output logic                  outValid,
    input  wire logic             outReady,
    output logic      [WIDTH-1:0] outData
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];   // Storage array.
    logic [AW-1:0]    wrPtr;         // Next slot to fill.
    logic [AW-1:0]    rdPtr;         // Oldest entry.
    logic [AW:0]      count;         // Entries held.
    wire              push = inValid && inReady;
    wire              pop  = outValid && outReady;

    // Full and empty come straight from the occupancy count.
    assign inReady  = (count != (AW+1)'(DEPTH));
    assign outValid = (count != '0);
    assign outData  = mem[rdPtr];

    // Storage is written without reset; only the pointers and count need one.
    always_ff @(posedge clk) begin
        if (push) begin
            mem[wrPtr] <= inData;
        end
    end

    // Pointers wrap at the depth, which need not be a power of two.
    always_ff @(posedge clk) begin
        if (rst) begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
        end else begin
            if (push) begin
                wrPtr <= (wrPtr == AW'(DEPTH-1)) ? '0 : wrPtr + 1'b1;
            end
            if (pop) begin
                rdPtr <= (rdPtr == AW'(DEPTH-1)) ? '0 : rdPtr + 1'b1;
            end
            count <= count + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

// ---------------------------------------------------------------------
// Mailbox top
// ---------------------------------------------------------------------
module host_coprocessor_mailbox (
    input  wire logic                        clk,
    input  wire logic                        rst,
    // Host side.
    input  wire mailbox_pkg::host_req_t      hostReq,
    output logic [7:0]                       hostRdData,
    output logic                             hostRdValid,
    output logic                             hostIntReqN,
    input  wire logic                        hostIntAck,
    output logic [7:0]                       hostVectorOut,
    output logic                             hostVectorOe,
    // Local processor side.
    input  wire mailbox_pkg::loc_req_t       locReq,
    output logic [7:0]                       locRdData,
    output logic                             locRdValid,
    input  wire logic                        localIntEnable,
    input  wire logic                        hostIntEnable,
    input  wire logic [7:0]                  uartIntReq,
    output logic                             locIntReq,
    input  wire logic                        locIntAck,
    output logic [7:0]                       locVectorOut,
    output logic                             locVectorOe,
    output logic                             uartAckGrant,
    output logic [7:0]                       flags
);
    // -----------------------------------------------------------------
    // Access edge detection
    // -----------------------------------------------------------------
    logic hostSelPrev;   // Host select one cycle ago.
    logic locSelPrev;    // Local select one cycle ago.
    logic hostAckPrev;   // Host acknowledge one cycle ago.
    logic locAckPrev;    // Local acknowledge one cycle ago.

    // Only a select's first cycle counts: one flag change, one request.
    wire hostAcc = hostReq.select && !hostSelPrev;
    wire locAcc  = locReq.select && !locSelPrev;
    wire hostAckEdge = hostIntAck && !hostAckPrev;
    wire locAckEdge  = locIntAck && !locAckPrev;

    always_ff @(posedge clk) begin
        if (rst) begin
            hostSelPrev <= 1'b0;
            locSelPrev  <= 1'b0;
            hostAckPrev <= 1'b0;
            locAckPrev  <= 1'b0;
        end else begin
            hostSelPrev <= hostReq.select;
            locSelPrev  <= locReq.select;
            hostAckPrev <= hostIntAck;
            locAckPrev  <= locIntAck;
        end
    end

    // -----------------------------------------------------------------
    // Decoded strobes
    // -----------------------------------------------------------------
    wire hostWr = hostAcc && hostReq.write;   // Host write edge.
    wire hostRd = hostAcc && !hostReq.write;  // Host read edge.
    wire locWr  = locAcc && locReq.write;     // Local write edge.
    wire locRd  = locAcc && !locReq.write;    // Local read edge.
    wire hostWrCmd  = hostWr && hostReq.addr == mailbox_pkg::HOST_CMD_STATUS;
    wire hostRdStat = hostRd && hostReq.addr == mailbox_pkg::HOST_CMD_STATUS;
    wire hostWrData = hostWr && hostReq.addr == mailbox_pkg::HOST_DATA;
    wire hostRdData_ = hostRd && hostReq.addr == mailbox_pkg::HOST_DATA;
    wire locWrStat  = locWr && locReq.addr == mailbox_pkg::LOC_CMD_STATUS;
    wire locWrOut   = locWr && locReq.addr == mailbox_pkg::LOC_DATA;
    wire locRdIn    = locRd && locReq.addr == mailbox_pkg::LOC_DATA;
    wire locWrVec   = locWr && locReq.addr == mailbox_pkg::LOC_VECTOR;

    // -----------------------------------------------------------------
    // Mailbox state
    // -----------------------------------------------------------------
    logic [7:0] cmdByte;       // Last host command; not reset.
    logic [7:0] inByte;        // Inbound data register; not reset.
    logic [7:0] outByte;       // Outbound data register; not reset.
    logic [7:0] hostVector;    // Latched host vector; not reset.
    logic [3:0] swStatus;      // Software status bits.
    logic       cmdEmpty;      // Host may send a command.
    logic       cmdAvail;      // Command waiting for local software.
    logic       statusEmpty;   // Host has read the last status.
    logic       inAvail;       // Inbound byte waiting for local read.
    logic       outAvail;      // Outbound byte waiting for host read.
    logic       outEmpty;      // Local side may write outbound data.
    logic       hostPend;      // Host interrupt line is asserted.

    // The inbound register reloads from the FIFO when empty or being read.
    logic       fifoInReady;
    logic       fifoOutValid;
    logic [7:0] fifoOutData;
    wire        inLoad = fifoOutValid && (!inAvail || locRdIn);

    mailbox_fifo #(
        .WIDTH (mailbox_pkg::FIFO_WIDTH),
        .DEPTH (mailbox_pkg::FIFO_DEPTH)
    ) inboundFifo (
        .clk      (clk),
        .rst      (rst),
        .inValid  (hostWrData),
        .inReady  (fifoInReady),
        .inData   (hostReq.data),
        .outValid (fifoOutValid),
        .outReady (inLoad),
        .outData  (fifoOutData)
    );

    // Command and outbound registers hold whatever was last written, the vector register the last write made
    // with hostIntEnable set; a write before the previous byte was taken simply replaces it.
    always_ff @(posedge clk) begin
        if (hostWrCmd) begin
            cmdByte <= hostReq.data;
        end
        if (inLoad) begin
            inByte <= fifoOutData;
        end
        if (locWrOut) begin
            outByte <= locReq.data;
        end
        if (locWrVec && hostIntEnable) begin
            hostVector <= locReq.data;
        end
    end

    // Command handshake; the host write wins over a same-cycle release.
    always_ff @(posedge clk) begin
        if (rst) begin
            cmdEmpty <= 1'b1;
            cmdAvail <= 1'b0;
        end else if (hostWrCmd) begin
            cmdEmpty <= 1'b0;
            cmdAvail <= 1'b1;
        end else if (locWrStat) begin
            // A local read of the command leaves both bits alone.
            cmdEmpty <= locReq.data[mailbox_pkg::STAT_CMD_EMPTY];
            if (locReq.data[mailbox_pkg::STAT_CMD_EMPTY]) begin
                cmdAvail <= 1'b0;
            end
        end
    end

    // Status exchange. There is no new-status bit in hardware, so a
    // software bit must serve. A host read wins over a same-cycle write.
    always_ff @(posedge clk) begin
        if (rst) begin
            swStatus    <= mailbox_pkg::SW_STATUS_RESET;
            statusEmpty <= 1'b1;
        end else begin
            if (locWrStat) begin
                swStatus <= locReq.data[mailbox_pkg::STAT_SW_HI:
                                        mailbox_pkg::STAT_SW_LO];
            end
            if (hostRdStat) begin
                statusEmpty <= 1'b1;
            end else if (locWrStat) begin
                statusEmpty <= 1'b0;
            end
        end
    end

    // Inbound flag: a reload in the read cycle keeps it set.
    always_ff @(posedge clk) begin
        if (rst) begin
            inAvail <= 1'b0;
        end else if (inLoad) begin
            inAvail <= 1'b1;
        end else if (locRdIn) begin
            inAvail <= 1'b0;
        end
    end

    // Outbound handshake; the local write wins over a same-cycle read.
    always_ff @(posedge clk) begin
        if (rst) begin
            outAvail <= 1'b0;
            outEmpty <= 1'b1;
        end else if (locWrOut) begin
            outAvail <= 1'b1;
            outEmpty <= 1'b0;
        end else if (hostRdData_) begin
            outAvail <= 1'b0;
            outEmpty <= 1'b1;
        end
    end

    // -----------------------------------------------------------------
    // Host interrupt
    // -----------------------------------------------------------------
    // A new enabled vector write wins over an acknowledge in the same
    // cycle, so the fresh request is never lost.
    always_ff @(posedge clk) begin
        if (rst) begin
            hostPend     <= 1'b0;
            hostVectorOe <= 1'b0;
        end else begin
            hostVectorOe <= hostAckEdge && hostPend;
            if (locWrVec && hostIntEnable) begin
                hostPend <= 1'b1;
            end else if (hostAckEdge && hostPend) begin
                hostPend <= 1'b0;
            end
        end
    end

    assign hostIntReqN   = !hostPend;
    assign hostVectorOut = hostVector;

    // -----------------------------------------------------------------
    // Local interrupt
    // -----------------------------------------------------------------
    logic mboxPend;   // Mailbox access request outstanding.
    logic turnUart;   // Serial sources get the next tie.
    wire  uartAny  = |uartIntReq;
    // Ties alternate so neither source class outranks the other.
    wire  grantMbx = locAckEdge && mboxPend &&
                     (!uartAny || !turnUart);
    wire  grantUrt = locAckEdge && uartAny && !grantMbx;

    always_ff @(posedge clk) begin
        if (rst) begin
            mboxPend     <= 1'b0;
            turnUart     <= 1'b0;
            locVectorOe  <= 1'b0;
            locVectorOut <= 8'h00;
            uartAckGrant <= 1'b0;
        end else begin
            locVectorOe  <= grantMbx;
            uartAckGrant <= grantUrt;
            if (grantMbx) begin
                locVectorOut <= mailbox_pkg::LOC_MAILBOX_VECTOR;
                turnUart     <= 1'b1;
            end else if (grantUrt) begin
                turnUart <= 1'b0;
            end
            // A new access wins over an acknowledge in the same cycle.
            if (hostAcc && localIntEnable) begin
                mboxPend <= 1'b1;
            end else if (grantMbx) begin
                mboxPend <= 1'b0;
            end
        end
    end

    assign locIntReq = mboxPend || uartAny;

    // -----------------------------------------------------------------
    // Read data
    // -----------------------------------------------------------------
    wire [7:0] hostStatus = {!inAvail || fifoInReady, outAvail, swStatus,
                             cmdEmpty, 1'b1};
    wire [7:0] flagByte   = {outEmpty, inAvail, 2'b00, hostPend, 1'b0,
                             statusEmpty, cmdAvail} |
                            mailbox_pkg::FLAG_ONES_MASK;
    wire [7:0] hostMux = hostReq.addr ? outByte : hostStatus;
    wire [7:0] locMux  = (locReq.addr == mailbox_pkg::LOC_CMD_STATUS) ?
                         cmdByte :
                         (locReq.addr == mailbox_pkg::LOC_DATA) ? inByte :
                         (locReq.addr == mailbox_pkg::LOC_FLAGS) ?
                         flagByte : 8'h00;

    // Read data is captured once per read access and held until the next read.
    always_ff @(posedge clk) begin
        if (rst) begin
            hostRdData  <= 8'h00;
            hostRdValid <= 1'b0;
            locRdData   <= 8'h00;
            locRdValid  <= 1'b0;
            flags       <= mailbox_pkg::FLAG_RESET;
        end else begin
            hostRdValid <= hostAcc && !hostReq.write;
            locRdValid  <= locAcc && !locReq.write;
            flags       <= flagByte;
            if (hostAcc && !hostReq.write) begin
                hostRdData <= hostMux;
            end
            if (locAcc && !locReq.write) begin
                locRdData <= locMux;
            end
        end
    end
endmodule

`default_nettype wire

// >>> inc/mailbox_pkg.sv
// Constants and carrier types shared by the host/coprocessor mailbox.
// Assumes a single 25 MHz clock domain and synchronous active-high reset.
`default_nettype none

package mailbox_pkg;

    // -----------------------------------------------------------------
    // Register selection
    // -----------------------------------------------------------------
    localparam logic       HOST_CMD_STATUS = 1'b0; // Command in / status out.
    localparam logic       HOST_DATA       = 1'b1; // Data in / data out.
    localparam logic [1:0] LOC_CMD_STATUS  = 2'h0; // Command / host status.
    localparam logic [1:0] LOC_DATA        = 2'h1; // Inbound / outbound data.
    localparam logic [1:0] LOC_FLAGS       = 2'h2; // Flag register (read).
    localparam logic [1:0] LOC_VECTOR      = 2'h3; // Host vector (write).

    // -----------------------------------------------------------------
    // Field positions in the host status and local flag bytes
    // -----------------------------------------------------------------
    localparam int STAT_IN_EMPTY  = 7; // Room for an inbound byte.
    localparam int STAT_OUT_AVAIL = 6; // Outbound data available.
    localparam int STAT_SW_HI     = 5; // Software status, top bit.
    localparam int STAT_SW_LO     = 2; // Software status, bottom bit.
    localparam int STAT_CMD_EMPTY = 1; // Command register empty.
    localparam int FLAG_OUT_EMPTY = 7; // Outbound data register empty.
    localparam int FLAG_IN_AVAIL  = 6; // Inbound byte available.
    localparam int FLAG_HOST_PEND = 3; // Host interrupt pending.
    localparam int FLAG_STAT_EMPT = 1; // Status read by host.
    localparam int FLAG_CMD_AVAIL = 0; // Command available.

    // Fixed values and reset values.
    localparam logic [7:0] LOC_MAILBOX_VECTOR = 8'hFC;  // Mailbox vector.
    localparam logic [7:0] FLAG_ONES_MASK     = 8'h34;  // D5, D4, D2 read 1.
    localparam logic [7:0] FLAG_RESET         = 8'hB6;  // Flag byte in reset.
    localparam logic [3:0] SW_STATUS_RESET    = 4'h0;   // Software status.
    localparam int         NUM_UART_SOURCES   = 8;      // Serial requesters.
    localparam int         FIFO_DEPTH         = 8;      // Inbound buffering.
    localparam int         FIFO_WIDTH         = 8;      // Byte wide.

    // -----------------------------------------------------------------
    // Carrier types
    // -----------------------------------------------------------------
    typedef struct packed {
        logic       select;    // Level, high for the whole bus cycle.
        logic       write;     // High for write, low for read.
        logic       addr;      // Register select.
        logic [7:0] data;      // Write data.
    } host_req_t;

    typedef struct packed {
        logic       select;    // Level, high for the whole bus cycle.
        logic       write;     // High for write, low for read.
        logic [1:0] addr;      // Register select.
        logic [7:0] data;      // Write data.
    } loc_req_t;

endpackage

`default_nettype wire

// >>> testbench/host_bus_model.sv
// Host processor model: bus cycles and interrupt acknowledge.
// Assumes calls come from one process, inputs change at falling edges.
`default_nettype none

module host_bus_model (
    input  wire logic                   clk,
    output var mailbox_pkg::host_req_t  hostReq,
    output logic                        hostIntAck,
    input  wire logic [7:0]             hostRdData,
    input  wire logic                   hostRdValid,
    input  wire logic                   hostIntReqN,
    input  wire logic [7:0]             hostVectorOut,
    input  wire logic                   hostVectorOe
);
    timeunit 1ns;
    timeprecision 1ns;
    int nStall = 0;   // Status polls that ran out before the bit set.

    initial begin
        hostReq = '0;
        hostIntAck = 1'b0;
    end

    // One bus cycle; when idle the data lines are turned over so that a
    // stale byte is never mistaken for a fresh one.
    task automatic cyc(input logic w, input logic a, input logic [7:0] d,
                       output logic [7:0] q);
        @(negedge clk);
        hostReq = '{select: 1'b1, write: w, addr: a, data: d};
        @(negedge clk);
        q = hostRdValid ? hostRdData : ~hostRdData;
        @(negedge clk);
        hostReq.select = 1'b0;
        hostReq.data = ~d;
        @(negedge clk);
    endtask

    // Polls the status byte until the given empty bit is set, then writes.
    task automatic put(input logic a, input int b, input logic [7:0] d);
        logic [7:0] s;
        for (int i = 0; i < 20; i++) begin
            cyc(1'b0, mailbox_pkg::HOST_CMD_STATUS, 8'h00, s);
            if (s[b] === 1'b1) break;
        end
        if (s[b] === 1'b1) cyc(1'b1, a, d, s);
        else nStall++;
    endtask

    // A real host acknowledges only a line that it sees raised.
    task automatic ack(output logic oe, output logic [7:0] v);
        @(negedge clk);
        hostIntAck = !hostIntReqN;
        @(negedge clk);
        oe = hostVectorOe;
        v = hostVectorOut;
        hostIntAck = 1'b0;
        @(negedge clk);
    endtask
endmodule

`default_nettype wire

// >>> testbench/host_coprocessor_mailbox_assertions.sv
// Concurrent checks on the mailbox top module's ports.
// Assumes one clock domain and the bind statement at the foot.
`default_nettype none

module host_coprocessor_mailbox_assertions (
    input wire logic                   clk,
    input wire logic                   rst,
    input wire mailbox_pkg::host_req_t hostReq,
    input wire logic                   hostRdValid,
    input wire logic                   hostIntReqN,
    input wire logic                   hostIntAck,
    input wire logic                   hostVectorOe,
    input wire mailbox_pkg::loc_req_t  locReq,
    input wire logic                   locRdValid,
    input wire logic                   localIntEnable,
    input wire logic                   hostIntEnable,
    input wire logic [7:0]             uartIntReq,
    input wire logic                   locIntReq,
    input wire logic [7:0]             locVectorOut,
    input wire logic                   locVectorOe,
    input wire logic                   uartAckGrant,
    input wire logic [7:0]             flags
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // A host access is taken only where its select rises.
    sequence hostAcc;
        $rose(hostReq.select);
    endsequence
    // An enabled local write of the host vector.
    sequence vecWr;
        $rose(locReq.select) && locReq.write &&
            locReq.addr == mailbox_pkg::LOC_VECTOR && hostIntEnable;
    endsequence

    AST_HOST_RD: assert property (hostAcc ##0 !hostReq.write |=>
        hostRdValid ##1 !hostRdValid) else $error("host read answer");
    AST_LOC_RD: assert property ($rose(locReq.select) && !locReq.write
        |=> locRdValid ##1 !locRdValid) else $error("local read answer");
    AST_LOC_INT_ON: assert property (hostAcc ##0 localIntEnable
        |=> locIntReq) else $error("no local request");
    AST_LOC_INT_OFF: assert property (hostAcc ##0
        (!localIntEnable && !locIntReq) ##1 (uartIntReq == 8'h00)
        |-> !locIntReq) else $error("request while disabled");
    AST_LOC_VEC: assert property (locVectorOe |->
        locVectorOut == mailbox_pkg::LOC_MAILBOX_VECTOR && !uartAckGrant)
        else $error("wrong local vector");
    AST_HOST_INT_ON: assert property (vecWr |=> !hostIntReqN)
        else $error("host line not raised");
    AST_HOST_INT_OFF: assert property (hostIntReqN && !hostIntEnable
        |=> hostIntReqN) else $error("host line raised while disabled");
    AST_HOST_ACK: assert property ($rose(hostIntAck) && !hostIntReqN &&
        !locReq.select |=> hostVectorOe && hostIntReqN ##1 !hostVectorOe)
        else $error("host acknowledge answer");
    AST_PEND_FLAG: assert property (1'b1 |=>
        flags[mailbox_pkg::FLAG_HOST_PEND] == !$past(hostIntReqN))
        else $error("pending flag mismatch");
    AST_STAT_EMPTY: assert property (hostAcc ##0 (!hostReq.write &&
        hostReq.addr == mailbox_pkg::HOST_CMD_STATUS) |=> ##1
        flags[mailbox_pkg::FLAG_STAT_EMPT]) else $error("status not empty");
endmodule

bind host_coprocessor_mailbox host_coprocessor_mailbox_assertions
    host_coprocessor_mailbox_assertions_i (.clk, .rst, .hostReq,
    .hostRdValid, .hostIntReqN, .hostIntAck, .hostVectorOe, .locReq,
    .locRdValid, .localIntEnable, .hostIntEnable, .uartIntReq, .locIntReq,
    .locVectorOut, .locVectorOe, .uartAckGrant, .flags);

`default_nettype wire

// >>> testbench/host_coprocessor_mailbox_tb_top.sv
// Self-checking bench for the host/coprocessor mailbox.
// Assumes package, design, checker and host model are compiled first.
`default_nettype none

module host_coprocessor_mailbox_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    localparam logic HC = mailbox_pkg::HOST_CMD_STATUS;
    localparam logic HD = mailbox_pkg::HOST_DATA;

    logic                   clk, rst, hostRdValid, hostIntReqN, hostIntAck;
    logic                   hostVectorOe, locRdValid, localIntEnable;
    logic                   hostIntEnable, locIntReq, locIntAck;
    logic                   locVectorOe, uartAckGrant;
    logic [7:0]             hostRdData, hostVectorOut, locRdData;
    logic [7:0]             uartIntReq, locVectorOut, flags;
    mailbox_pkg::host_req_t hostReq;
    mailbox_pkg::loc_req_t  locReq;
    int                     nFail, nChecks;

    host_coprocessor_mailbox host_coprocessor_mailbox_i (.clk, .rst,
        .hostReq, .hostRdData, .hostRdValid, .hostIntReqN, .hostIntAck,
        .hostVectorOut, .hostVectorOe, .locReq, .locRdData, .locRdValid,
        .localIntEnable, .hostIntEnable, .uartIntReq, .locIntReq,
        .locIntAck, .locVectorOut, .locVectorOe, .uartAckGrant, .flags);
    host_bus_model host_bus_model_i (.clk, .hostReq, .hostIntAck,
        .hostRdData, .hostRdValid, .hostIntReqN, .hostVectorOut,
        .hostVectorOe);

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        nChecks++;
        if (got !== exp) begin
            nFail++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic hr(input logic a, output logic [7:0] q);
        host_bus_model_i.cyc(1'b0, a, 8'h00, q);
    endtask
    task automatic hw(input logic a, input logic [7:0] d);
        logic [7:0] q;
        host_bus_model_i.cyc(1'b1, a, d, q);
    endtask
    // Local bus cycle; data lines turn over once the cycle is done.
    task automatic lc(input logic w, input logic [1:0] a,
                      input logic [7:0] d, output logic [7:0] q);
        @(negedge clk);
        locReq = '{select: 1'b1, write: w, addr: a, data: d};
        @(negedge clk);
        q = locRdData;
        @(negedge clk);
        locReq.select = 1'b0;
        locReq.data = ~d;
        @(negedge clk);
    endtask
    task automatic lack(output logic oe, output logic ug);
        @(negedge clk);
        locIntAck = 1'b1;
        @(negedge clk);
        oe = locVectorOe;
        ug = uartAckGrant;
        locIntAck = 1'b0;
        @(negedge clk);
    endtask

    task automatic tFlow();
        logic [7:0] q;
        chk(flags, 8'hB6);
        hr(HC, q);
        chk(q, 8'h83);
        host_bus_model_i.put(HC, mailbox_pkg::STAT_CMD_EMPTY, 8'h5A);
        chk(flags, 8'hB7);
        hr(HC, q);
        chk(q, 8'h81);
        hw(HC, 8'hA5);
        lc(1'b0, mailbox_pkg::LOC_CMD_STATUS, 8'h00, q);
        chk(q, 8'hA5);
        chk(flags, 8'hB7);
        lc(1'b1, mailbox_pkg::LOC_CMD_STATUS, 8'h02, q);
        chk(flags, 8'hB4);
        hr(HC, q);
        chk(q, 8'h83);
        chk(flags, 8'hB6);
        lc(1'b1, mailbox_pkg::LOC_CMD_STATUS, 8'hFE, q);
        chk(flags, 8'hB4);
        hr(HC, q);
        chk(q, 8'hBF);
        chk(flags, 8'hB6);
        lc(1'b1, mailbox_pkg::LOC_DATA, 8'hC3, q);
        chk(flags, 8'h36);
        hr(HC, q);
        chk(q, 8'hFF);
        hr(HD, q);
        chk(q, 8'hC3);
        chk(flags, 8'hB6);
    endtask

    // Fills the inbound path until it refuses, then drains it slowly.
    task automatic tIn();
        logic [7:0] q;
        for (logic [7:0] v = 8'h10; v < 8'h19; v++)
            host_bus_model_i.put(HD, mailbox_pkg::STAT_IN_EMPTY, v);
        hr(HC, q);
        chk(q, 8'h3F);
        chk(flags, 8'hF6);
        hw(HD, 8'hEE);
        for (int i = 0; i < 9; i++) begin
            lc(1'b0, mailbox_pkg::LOC_DATA, 8'h00, q);
            chk(q, 8'h10 + 8'(i));
        end
        chk(flags, 8'hB6);
        chk(16'(host_bus_model_i.nStall), 16'h0000);
    endtask

    task automatic tInt();
        logic       oe, ug;
        logic [7:0] v;
        int         nm, nu;
        hostIntEnable = 1'b1;
        lc(1'b1, mailbox_pkg::LOC_VECTOR, 8'h9E, v);
        chk(flags, 8'hBE);
        host_bus_model_i.ack(oe, v);
        chk({oe, v}, 9'h19E);
        chk(flags, 8'hB6);
        hostIntEnable = 1'b0;
        lc(1'b1, mailbox_pkg::LOC_VECTOR, 8'h55, v);
        chk({hostIntReqN, hostVectorOut}, 9'h19E);
        hr(HC, v);
        chk({7'h00, locIntReq}, 8'h00);
        localIntEnable = 1'b1;
        hr(HC, v);
        chk({7'h00, locIntReq}, 8'h01);
        lack(oe, ug);
        chk({oe, ug, locIntReq, locVectorOut}, 11'h4FC);
        uartIntReq = 8'h01;
        hr(HC, v);
        nm = 0;
        nu = 0;
        repeat (2) begin
            lack(oe, ug);
            nm += oe;
            nu += ug;
        end
        chk(8'(nm * 16 + nu), 8'h11);
        uartIntReq = 8'h00;
        localIntEnable = 1'b0;
    endtask

    task automatic closeOut();
        $display("Comparisons %0d, mismatches %0d", nChecks, nFail);
        if (nFail == 0 && nChecks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask

    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    initial begin
        {rst, nFail, nChecks, locReq, locIntAck} = '0;
        rst = 1'b1;
        {localIntEnable, hostIntEnable, uartIntReq} = '0;
        repeat (20) @(negedge clk);
        rst = 1'b0;
        tFlow();
        tIn();
        tInt();
        closeOut();
    end
    // Watchdog: the sequence needs well under a tenth of this span.
    initial begin
        #(40 * 20000);
        nFail++;
        closeOut();
    end
endmodule

`default_nettype wire
